/* fes_pkg.sv */
// constants, types and register map of the flash erase/program sequencer
// Behaviour
// (R1) software keeps the timing generator clock between about 257 kHz and 476 kHz
// (R2) timing clock taken from aux, sub-main or main clock, then divided
// (R3) erased bits read 1; programming only clears bits, erase restores ones
// (R4) mass/erase bits: 01 segment, 10 all main, 11 main plus info
// (R5) with erase mode set, any write inside the range starts the erase
// (R6) busy sets right after the erase trigger write, holds for whole cycle
// (R7) erase end clears busy and both erase-select bits automatically
// (R8) erase duration is fixed, independent of flash size
// (R9) trigger write outside the erase range is dropped silently
// (R10) interrupts masked during erase; pending flags wait until unmasked
// (R11) erase started from flash holds the cpu until the cycle ends
// (R12) erase from ram: cpu polls busy before touching flash
// (R13) flash access during a ram-started erase sets access violation
// (R14) block/program enable bits: 01 single word, 11 block programming
// (R15) interrupts masked during programming; pending flags wait until unmasked
// (R16) any cpu write to flash in a program mode is a program request
// (R17) busy stays set while programming, clears on completion
// (R18) word program started from flash stalls the cpu until done
// (R19) after ram-started word program, flash access while busy is a violation
// (R20) word program powers whole 64-byte block for 32 of 35 timing ticks
// (R21) software tracks cumulative program time and erases before the limit
// (R22) block mode keeps programming voltage on across the whole block
// (R23) control writes need key A5 in upper byte, else key flag and reset
// (R24) control register reads return 96 in the upper byte
// (R25) flash write with program enable clear sets access violation, no change
// (R26) fetches during a flash-started operation return the jump-to-self opcode
// (R27) erase length is a fixed timing-tick count held as a parameter
package fes_pkg;
    localparam logic [7:0] FES_OFF_CTRL = 8'h00;  // mode bits
    localparam logic [7:0] FES_OFF_CLK = 8'h04;   // timing clock source/divider
    localparam logic [7:0] FES_OFF_STAT = 8'h08;  // busy and flags
    localparam logic [7:0] FES_WR_KEY = 8'hA5;
    localparam logic [7:0] FES_RD_KEY = 8'h96;
    localparam logic [15:0] FES_JMP_SELF = 16'h3FFF;
    localparam int FES_B_ERASE = 1;
    localparam int FES_B_MASS = 2;
    localparam int FES_B_PE = 6;
    localparam int FES_B_BPE = 7;
    localparam int FES_B_BUSY = 0;
    localparam int FES_B_KVF = 1;
    localparam int FES_B_AVF = 2;
    localparam int FES_F_SRC = 6;   // source field [7:6], divider field [5:0]
    localparam logic [15:0] FES_INFO_LO = 16'h1000;
    localparam logic [15:0] FES_INFO_HI = 16'h10FF;
    localparam logic [15:0] FES_MAIN_LO = 16'hF000;
    localparam logic [15:0] FES_MAIN_HI = 16'hFFFF;
    localparam logic [15:0] FES_INFO_SEG_MASK = 16'h007F;  // 128-byte segments
    localparam logic [15:0] FES_MAIN_SEG_MASK = 16'h01FF;  // 512-byte segments
    localparam logic [15:0] FES_WORD_TICKS = 16'h0023;     // 35 ticks per word
    localparam logic [15:0] FES_HV_FIRST = 16'h0001;       // hv on ticks 1..32
    localparam logic [15:0] FES_HV_LAST = 16'h0020;
    localparam int FES_ERASE_TICKS = 4800;
    localparam int FES_BLK_TICKS = 16;

    typedef enum logic [1:0] {
        FES_IDLE = 2'b00,
        FES_ERASE = 2'b01,
        FES_WORD = 2'b10,
        FES_BLOCK = 2'b11
    } fes_st_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fes_mem_req_t;

    typedef struct packed {
        logic prog;
        logic erase;
        logic hv_on;
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] lo;
        logic [15:0] hi;
    } fes_arr_cmd_t;

    typedef struct packed {
        fes_st_t st;
        logic erase;
        logic mass_erase_select;
        logic program_enable;
        logic block_program_enable;
        logic [1:0] src;
        logic [5:0] div;
        logic key_violation_flag;
        logic access_violation_flag;
        logic op_flash;
        logic word_act;
        logic [5:0] dcnt;
        logic [15:0] cnt;
        logic dp_wr;
        logic dp_rd1;
        logic dp_rd2;
        logic [7:0] dp_addr;
        logic [31:0] hrdata;
        logic [15:0] mrdata;
        logic system_reset_pulse;
        fes_arr_cmd_t arr;
    } fes_state_t;

    localparam fes_state_t FES_STATE_RST = '0;
endpackage

/* fes_top.sv */
// flash erase/program sequencer with ahb-lite control registers
module fes_top import fes_pkg::*; #(
    parameter int ERASE_TICKS = FES_ERASE_TICKS,
    parameter int BLK_TICKS = FES_BLK_TICKS
) (
    input wire logic sys_clk,                // 200 MHz
    input wire logic rst_b,                  // async, active low
    input wire logic hsel,                   // ahb-lite slave select
    input wire logic [31:0] haddr,           // byte address
    input wire logic [1:0] htrans,           // transfer type
    input wire logic hwrite,                 // write when high
    input wire logic [2:0] hsize,            // word only
    input wire logic [31:0] hwdata,          // write data
    input wire logic hready,                 // bus ready
    output logic hreadyout,                  // slave ready
    output logic [31:0] hrdata,              // read data
    output logic hresp,                      // always okay
    input wire logic aux_clk_tick,           // aux clock edge pulse
    input wire logic sub_main_clock_tick,    // sub-main clock edge pulse
    input wire logic main_clk_tick,          // main clock edge pulse
    input wire fes_mem_req_t mem_req,        // cpu flash access
    input wire logic mem_in_flash,           // cpu executes from flash
    output logic [15:0] mem_rdata,           // flash read data, next cycle
    output logic cpu_hold,                   // stall cpu
    output logic irq_mask,                   // mask interrupts
    output logic busy,                       // operation active
    output logic access_violation_flag,      // to nmi logic
    output logic system_reset_pulse,         // key violation reset
    input wire logic [15:0] arr_rdata,       // array word at mem_req.addr
    output fes_arr_cmd_t arr_cmd             // array command
);
    generate
        if (ERASE_TICKS < 2 || ERASE_TICKS > 65535 || BLK_TICKS < 1 || BLK_TICKS > 65535) begin : g_chk
            $error("fes_top: tick parameter out of range");
        end
    endgenerate

    localparam logic [15:0] ERASE_LAST = 16'(ERASE_TICKS - 1);
    localparam logic [15:0] BLK_LAST = 16'(BLK_TICKS - 1);

    fes_state_t q;
    fes_state_t d;

    // address lies in main or information memory
    function automatic logic in_flash(input logic [15:0] a);
        in_flash = (a >= FES_INFO_LO && a <= FES_INFO_HI) || (a >= FES_MAIN_LO && a <= FES_MAIN_HI);
    endfunction

    function automatic logic in_main(input logic [15:0] a);
        in_main = a >= FES_MAIN_LO && a <= FES_MAIN_HI;
    endfunction

    logic ap;
    logic is_busy;
    logic tick;
    logic src_pulse;
    logic erase_hit;
    logic [15:0] seg_lo;
    logic [15:0] seg_hi;
    logic [15:0] rd_val;
    logic blk_open;
    logic bad_key;

    assign is_busy = q.st != FES_IDLE;
    // block mode accepts control writes between words only
    assign blk_open = q.st == FES_BLOCK && !q.word_act;
    assign ap = hsel && htrans[1] && hready;
    assign bad_key = q.dp_wr && hwdata[15:8] != FES_WR_KEY;

    // timing clock source pick; the generator only runs while busy
    always_comb begin
        case (q.src)  // see (R2)
            2'b00: src_pulse = aux_clk_tick;
            2'b01: src_pulse = sub_main_clock_tick;
            default: src_pulse = main_clk_tick;
        endcase
    end

    // erase range of the selected mode around the trigger address
    always_comb begin
        seg_lo = FES_MAIN_LO;
        seg_hi = FES_MAIN_HI;
        erase_hit = 1'b0;
        if (!q.mass_erase_select && q.erase) begin  // see (R4)
            seg_lo = in_main(mem_req.addr) ? (mem_req.addr & ~FES_MAIN_SEG_MASK)
                                           : (mem_req.addr & ~FES_INFO_SEG_MASK);
            seg_hi = in_main(mem_req.addr) ? (seg_lo | FES_MAIN_SEG_MASK)
                                           : (seg_lo | FES_INFO_SEG_MASK);
            erase_hit = in_flash(mem_req.addr);
        end else if (q.mass_erase_select && !q.erase) begin
            erase_hit = in_main(mem_req.addr);
        end else if (q.mass_erase_select && q.erase) begin
            seg_lo = FES_INFO_LO;  // gap between the areas holds no cells
            erase_hit = in_flash(mem_req.addr);
        end
    end

    // register read view, key byte on top
    always_comb begin
        rd_val = 16'h0000;
        case (q.dp_addr)
            FES_OFF_CTRL: begin
                rd_val[FES_B_ERASE] = q.erase;
                rd_val[FES_B_MASS] = q.mass_erase_select;
                rd_val[FES_B_PE] = q.program_enable;
                rd_val[FES_B_BPE] = q.block_program_enable;
                rd_val[15:8] = FES_RD_KEY;  // see (R24)
            end
            FES_OFF_CLK: rd_val = {FES_RD_KEY, q.src, q.div};  // see (R24)
            FES_OFF_STAT: begin
                rd_val[FES_B_BUSY] = is_busy;
                rd_val[FES_B_KVF] = q.key_violation_flag;
                rd_val[FES_B_AVF] = q.access_violation_flag;
                rd_val[15:8] = FES_RD_KEY;  // see (R24)
            end
            default: rd_val = 16'h0000;  // unmapped reads as zero
        endcase
    end

    // next state: bus first so hardware sets below win over clears
    always_comb begin
        d = q;
        tick = 1'b0;
        d.arr.prog = 1'b0;
        d.arr.erase = 1'b0;
        d.system_reset_pulse = 1'b0;
        d.dp_rd2 = q.dp_rd1;
        d.dp_rd1 = 1'b0;
        d.dp_wr = 1'b0;

        // ahb-lite: reads take one wait state so writes just done are seen
        if (ap) begin
            d.dp_addr = haddr[7:0];
            d.dp_wr = hwrite;
            d.dp_rd1 = !hwrite;
        end
        if (q.dp_rd1) begin
            d.hrdata = {16'h0000, rd_val};
        end
        if (bad_key) begin
            d.key_violation_flag = 1'b1;  // see (R23)
            d.system_reset_pulse = 1'b1;  // see (R23)
        end else if (q.dp_wr) begin
            case (q.dp_addr)
                FES_OFF_CTRL: begin
                    if (is_busy && !blk_open) begin
                        d.access_violation_flag = 1'b1;
                    end else begin
                        d.erase = hwdata[FES_B_ERASE];
                        d.mass_erase_select = hwdata[FES_B_MASS];
                        d.program_enable = hwdata[FES_B_PE];
                        d.block_program_enable = hwdata[FES_B_BPE];
                    end
                end
                FES_OFF_CLK: begin
                    if (is_busy) begin
                        d.access_violation_flag = 1'b1;
                    end else begin
                        d.src = hwdata[FES_F_SRC +: 2];  // see (R2)
                        d.div = hwdata[5:0];             // see (R2)
                    end
                end
                FES_OFF_STAT: begin
                    // flags clear by writing zero
                    if (!hwdata[FES_B_KVF]) begin
                        d.key_violation_flag = 1'b0;
                    end
                    if (!hwdata[FES_B_AVF]) begin
                        d.access_violation_flag = 1'b0;
                    end
                end
                default: d.dp_wr = 1'b0;  // unmapped write ignored
            endcase
        end

        // timing generator divides the source by divider+1
        if (!is_busy) begin
            d.dcnt = 6'h00;
        end else if (src_pulse) begin
            if (q.dcnt == q.div) begin  // see (R2)
                d.dcnt = 6'h00;
                tick = 1'b1;
            end else begin
                d.dcnt = q.dcnt + 6'h01;
            end
        end

        // sequencer
        case (q.st)
            FES_ERASE: begin
                if (tick) begin
                    d.cnt = q.cnt + 16'h0001;
                    if (q.cnt == ERASE_LAST) begin  // see (R8) (R27)
                        d.st = FES_IDLE;             // see (R7)
                        d.erase = 1'b0;              // see (R7)
                        d.mass_erase_select = 1'b0;  // see (R7)
                    end
                end
            end
            FES_WORD: begin
                if (tick) begin
                    d.cnt = q.cnt + 16'h0001;
                    // whole 64-byte block under voltage for 32 of 35 ticks
                    d.arr.hv_on = d.cnt >= FES_HV_FIRST && d.cnt <= FES_HV_LAST;  // see (R20)
                    if (d.cnt == FES_WORD_TICKS) begin
                        d.st = FES_IDLE;  // see (R17)
                    end
                end
            end
            FES_BLOCK: begin
                if (q.word_act && tick) begin
                    d.cnt = q.cnt + 16'h0001;
                    if (q.cnt == BLK_LAST) begin
                        d.word_act = 1'b0;
                    end
                end
                // block ends once software drops block mode between words
                if (blk_open && !q.block_program_enable) begin
                    d.st = FES_IDLE;       // see (R17)
                    d.arr.hv_on = 1'b0;    // see (R22)
                end
            end
            default: d.st = FES_IDLE;
        endcase

        // cpu side of the flash
        if (mem_req.valid && !mem_req.write) begin
            d.mrdata = is_busy ? FES_JMP_SELF : arr_rdata;  // see (R26)
            if (is_busy && q.st != FES_BLOCK && !q.op_flash && in_flash(mem_req.addr)) begin
                d.access_violation_flag = 1'b1;  // see (R13) (R19)
            end
        end else if (mem_req.valid && in_flash(mem_req.addr)) begin
            if (is_busy) begin
                if (blk_open && q.block_program_enable) begin
                    d.word_act = 1'b1;  // see (R16) (R22)
                    d.cnt = 16'h0000;
                    d.arr.prog = 1'b1;
                    d.arr.addr = mem_req.addr;
                    d.arr.data = mem_req.wdata & arr_rdata;  // see (R3)
                end else begin
                    d.access_violation_flag = 1'b1;  // see (R13) (R19)
                end
            end else if (q.erase || q.mass_erase_select) begin
                if (erase_hit) begin  // see (R9)
                    d.st = FES_ERASE;  // see (R5) (R6)
                    d.cnt = 16'h0000;
                    d.op_flash = mem_in_flash;
                    d.arr.erase = 1'b1;
                    d.arr.lo = seg_lo;
                    d.arr.hi = seg_hi;
                end
            end else if (q.program_enable) begin
                d.st = q.block_program_enable ? FES_BLOCK : FES_WORD;  // see (R14) (R16)
                d.op_flash = mem_in_flash && !q.block_program_enable;
                d.word_act = q.block_program_enable;
                d.arr.hv_on = q.block_program_enable;  // see (R22)
                d.cnt = 16'h0000;
                d.arr.prog = 1'b1;
                d.arr.addr = mem_req.addr;
                d.arr.data = mem_req.wdata & arr_rdata;  // see (R3)
            end else begin
                d.access_violation_flag = 1'b1;  // see (R25)
            end
        end
    end

    // single state register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= FES_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // outputs
    assign hreadyout = !q.dp_rd1;
    assign hrdata = q.hrdata;
    assign hresp = 1'b0;
    assign mem_rdata = q.mrdata;
    assign busy = is_busy;                                     // see (R6) (R17)
    assign irq_mask = is_busy;                                 // see (R10) (R15)
    assign cpu_hold = is_busy && q.op_flash && q.st != FES_BLOCK;  // see (R11) (R18)
    assign access_violation_flag = q.access_violation_flag;
    assign system_reset_pulse = q.system_reset_pulse;
    assign arr_cmd = q.arr;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic erase_trig;
    logic word_trig;
    assign erase_trig = mem_req.valid && mem_req.write && !is_busy
        && (q.erase || q.mass_erase_select) && erase_hit;
    assign word_trig = mem_req.valid && mem_req.write && !is_busy && in_flash(mem_req.addr)
        && !q.erase && !q.mass_erase_select && q.program_enable && !q.block_program_enable;

    sequence s_erase_end;
        q.st == FES_ERASE && tick && q.cnt == ERASE_LAST;
    endsequence
    sequence s_idle_clean;
        !busy && !q.erase && !q.mass_erase_select;
    endsequence

    a_erase_busy_set: assert property (erase_trig |=> busy && q.cnt == 16'h0000) // see (R6)
        else $error("busy not set after erase trigger");
    a_erase_auto_clear: assert property (s_erase_end |=> s_idle_clean) // see (R7)
        else $error("erase end did not clear busy and mode bits");
    a_erase_no_early: assert property (q.st == FES_ERASE && !(tick && q.cnt == ERASE_LAST)
        |=> q.st == FES_ERASE) // see (R27)
        else $error("erase ended before its tick count");
    a_mass_info_drop: assert property (mem_req.valid && mem_req.write && !is_busy
        && q.mass_erase_select && !q.erase && !in_main(mem_req.addr) && !q.dp_wr
        |=> !busy && $stable(access_violation_flag)) // see (R9)
        else $error("out of range erase trigger was not ignored");
    a_irq_mask_busy: assert property ((erase_trig || word_trig) |=> irq_mask && busy // see (R10)
        && cpu_hold == $past(mem_in_flash))
        else $error("interrupt mask or cpu hold wrong after trigger");
    a_word_hv_window: assert property (q.st == FES_WORD && q.cnt >= FES_HV_FIRST
        && q.cnt <= FES_HV_LAST |-> arr_cmd.hv_on) // see (R20)
        else $error("programming voltage off inside word window");
    a_word_hold_flash: assert property (word_trig && mem_in_flash
        |=> cpu_hold [*3]) // see (R18)
        else $error("cpu not held during flash-started word program");
    a_fetch_jump_self: assert property (mem_req.valid && !mem_req.write && busy
        |=> mem_rdata == FES_JMP_SELF) // see (R26)
        else $error("fetch during operation did not return jump-to-self");
    a_write_no_enable: assert property (mem_req.valid && mem_req.write && !is_busy
        && in_flash(mem_req.addr) && !q.erase && !q.mass_erase_select && !q.program_enable
        |=> access_violation_flag && !arr_cmd.prog) // see (R25)
        else $error("write without enable not flagged");
    a_bad_key_reset: assert property (bad_key |=> system_reset_pulse
        && q.key_violation_flag ##1 !system_reset_pulse) // see (R23)
        else $error("bad key did not raise flag and one reset pulse");
    a_read_key_byte: assert property (q.dp_rd2 && (q.dp_addr == FES_OFF_CTRL
        || q.dp_addr == FES_OFF_STAT) |-> hreadyout && hrdata[15:8] == FES_RD_KEY) // see (R24)
        else $error("register read lacks key byte");
endmodule

/* fes_cpu_model.sv */
// cpu core and flash array model facing the sequencer memory port
module fes_cpu_model import fes_pkg::*; (
    input wire logic sys_clk,         // system clock
    input wire fes_arr_cmd_t arr_cmd, // array command
    output fes_mem_req_t mem_req,     // cpu flash access
    output logic mem_in_flash,        // code runs from flash
    output logic [15:0] arr_rdata     // array word
);
    timeunit 1ns;
    timeprecision 100ps;
    // main and info alias on the low index bits, enough for these tests
    logic [15:0] mem [0:2047];
    initial begin
        mem_req = '0;
        mem_in_flash = 1'b0;
        foreach (mem[k]) mem[k] = 16'hFFFF;
    end
    assign arr_rdata = mem[mem_req.addr[11:1]];
    // programming only clears bits, erase brings back ones
    always @(posedge sys_clk) begin
        if (arr_cmd.prog)
            mem[arr_cmd.addr[11:1]] <= arr_cmd.data;
        if (arr_cmd.erase)
            for (int k = 0; k < 2048; k++)
                if (k >= arr_cmd.lo[11:1] && k <= arr_cmd.hi[11:1])
                    mem[k] <= 16'hFFFF;
    end
    // one access per cycle; released lines show no stale value
    task automatic access(input logic w, f, fl, input logic [15:0] a, d);
        @(posedge sys_clk);  // launch on an edge, never between edges
        mem_req <= '{1'b1, w, f, a, d};
        mem_in_flash <= fl;
        @(posedge sys_clk);
        mem_req <= '{1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

/* fes_top_test.sv */
// self-checking bench for the flash erase/program sequencer
module fes_top_test import fes_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_b, hsel, hwrite, main_tick, sub_tick, hreadyout, hresp, cpu_hold;
    logic irq_mask, busy, avf, srp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] mem_rdata, arr_rdata;
    fes_mem_req_t mem_req;
    logic mem_in_flash;
    fes_arr_cmd_t arr_cmd;
    int failures, compares, hv_n, busy_n;
    fes_top #(.ERASE_TICKS(4), .BLK_TICKS(2)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .aux_clk_tick(1'b0), .sub_main_clock_tick(sub_tick),
        .main_clk_tick(main_tick),
        .mem_req(mem_req), .mem_in_flash(mem_in_flash), .mem_rdata(mem_rdata),
        .cpu_hold(cpu_hold), .irq_mask(irq_mask), .busy(busy), .access_violation_flag(avf),
        .system_reset_pulse(srp), .arr_rdata(arr_rdata), .arr_cmd(arr_cmd));
    fes_cpu_model cpu (.sys_clk(sys_clk), .arr_cmd(arr_cmd), .mem_req(mem_req),
        .mem_in_flash(mem_in_flash), .arr_rdata(arr_rdata));
    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        repeat (50) begin
            @(posedge sys_clk);
            if (hreadyout === 1'b1) return;
        end
        failures++;
        wrap_up();
    endtask
    // one single-word ahb-lite transfer, read data left in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);  // launch on an edge, never between edges
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {16'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask
    // count busy and programming-voltage cycles until the operation ends
    task automatic run_out();
        busy_n = 0;
        hv_n = 0;
        repeat (300) begin
            #1;
            if (busy !== 1'b1) return;
            busy_n++;
            if (arr_cmd.hv_on === 1'b1) hv_n++;
            @(posedge sys_clk);
        end
        failures++;
        wrap_up();
    endtask
    task automatic t_regs();
        bus(1'b0, FES_OFF_CTRL, 16'h0);
        chk(rd | {31'h0, hresp}, 32'h0000_9600);
        bus(1'b0, 8'h40, 16'h0);
        chk(rd, 32'h0);
    endtask
    // word program from flash with the timing clock on the main source
    task automatic t_word();
        bus(1'b1, FES_OFF_CLK, 16'hA580);
        bus(1'b1, FES_OFF_CTRL, 16'hA540);
        cpu.access(1'b1, 1'b0, 1'b1, 16'hF002, 16'h0123);
        #1;
        chk({busy, cpu_hold, irq_mask}, 3'b111);
        run_out();
        chk(hv_n, 32);
        cpu.access(1'b0, 1'b0, 1'b0, 16'hF002, 16'h0);
        #1;
        chk(mem_rdata, 16'h0123);
    endtask
    // every erase mode started from ram, with a forbidden read while busy
    task automatic t_erase();
        logic [15:0] m [3] = '{16'h02, 16'h04, 16'h06};
        logic [31:0] r [3] = '{32'hF000_F1FF, 32'hF000_FFFF, 32'h1000_FFFF};
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, FES_OFF_CTRL, 16'hA500 | m[i]);
            cpu.access(1'b1, 1'b0, 1'b0, 16'hF002, 16'h0);
            #1;
            chk({arr_cmd.lo, arr_cmd.hi}, r[i]);
            chk({busy, cpu_hold, irq_mask}, 3'b101);
            cpu.access(1'b0, 1'b0, 1'b0, 16'hF010, 16'h0);
            #1;
            chk(avf, 1'b1);
            run_out();
            // four ticks, one a cycle; two cycles pass before the count starts
            chk(busy_n, 2);
            bus(1'b0, FES_OFF_CTRL, 16'h0);
            chk(rd, 32'h0000_9600);
            bus(1'b1, FES_OFF_STAT, 16'hA500);
        end
    endtask
    // stray trigger, erase from flash, and a write with programming off
    task automatic t_misc();
        bus(1'b1, FES_OFF_CTRL, 16'hA504);
        cpu.access(1'b1, 1'b0, 1'b0, 16'h1000, 16'h0);
        #1;
        chk({busy, avf}, 2'b00);
        bus(1'b1, FES_OFF_CTRL, 16'hA502);
        cpu.access(1'b1, 1'b0, 1'b1, 16'hF200, 16'h0);
        #1;
        chk(cpu_hold, 1'b1);
        cpu.access(1'b0, 1'b1, 1'b1, 16'hF004, 16'h0);
        #1;
        chk(mem_rdata, FES_JMP_SELF);
        run_out();
        chk({cpu_hold, avf}, 2'b00);
        cpu.access(1'b1, 1'b0, 1'b0, 16'hF004, 16'h0);
        #1;
        chk({arr_cmd.prog, avf}, 2'b01);
    endtask
    // block programming from ram: voltage held across words until block bit drops
    task automatic t_block();
        bus(1'b1, FES_OFF_CTRL, 16'hA5C0);
        cpu.access(1'b1, 1'b0, 1'b0, 16'hF010, 16'h0F0F);
        #1;
        chk({busy, cpu_hold, arr_cmd.hv_on}, 3'b101);
        repeat (4) @(posedge sys_clk);
        cpu.access(1'b1, 1'b0, 1'b0, 16'hF012, 16'h00FF);
        repeat (4) @(posedge sys_clk);
        #1;
        chk({busy, arr_cmd.hv_on}, 2'b11);
        bus(1'b1, FES_OFF_CTRL, 16'hA500);
        run_out();
        chk(arr_cmd.hv_on, 1'b0);
        cpu.access(1'b0, 1'b0, 1'b0, 16'hF012, 16'h0);
        #1;
        chk(mem_rdata, 16'h00FF);
    endtask
    // erase timed from sub-main divided by two; main source stopped so a wrong pick hangs
    task automatic t_div();
        bus(1'b1, FES_OFF_CLK, 16'hA541);
        main_tick <= 1'b0;
        bus(1'b0, FES_OFF_CLK, 16'h0);
        chk(rd, 32'h0000_9641);
        bus(1'b1, FES_OFF_CTRL, 16'hA502);
        cpu.access(1'b1, 1'b0, 1'b0, 16'hF002, 16'h0);
        run_out();
        chk(busy_n, 8);
    endtask
    // bad key: reset pulse and key flag
    task automatic t_key();
        int seen;
        seen = 0;
        bus(1'b1, FES_OFF_CTRL, 16'h1240);
        repeat (3) begin
            #1;
            if (srp === 1'b1) seen++;
            @(posedge sys_clk);
        end
        chk(seen, 1);
        bus(1'b0, FES_OFF_STAT, 16'h0);
        chk(rd & 32'hFFFF_FFFE, 32'h0000_9606);
    endtask
    // reset, then the scenarios in turn
    initial begin
        failures = 0;
        compares = 0;
        rst_b = 1'b0;
        {main_tick, sub_tick} = 2'b11;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_word();
        t_erase();
        t_misc();
        t_block();
        t_div();
        t_key();
        wrap_up();
    end
endmodule
